// [inc/seq0s_pkg.sv]
// Constants and types for the sequencer-0 sample input select register.
// Overview of operation
// - Bits 29:28 select input for eighth sample
// - Bits 25:24 select input for seventh sample
// - Bits 21:20 select input for sixth sample
// - Field value is the analog pin number
// - Reserved bits read zero, writes ignored
// - Lower fields serve samples one to five
// - Read/write word at 0x040, resets zero
package seq0s_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int FIELD_W = 2;
	localparam int NUM_FIELDS = 8;
	localparam int FIELD_STRIDE = 4;
	localparam int STEP_W = 3;
	localparam int PIN_COUNT = 4;

	localparam logic [ADDR_W-1:0] SEL_REG_OFFSET = 8'h40;
	localparam logic [DATA_W-1:0] SEL_REG_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] SEL_FIELD_MASK = 32'h33333333;
	localparam logic [DATA_W-1:0] SEL_RSVD_MASK = 32'hcccccccc;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;
	localparam logic [FIELD_W-1:0] FIELD_RESET = 2'h0;

	localparam int FIRST_LSB = 0;
	localparam int SECOND_LSB = 4;
	localparam int THIRD_LSB = 8;
	localparam int FOURTH_LSB = 12;
	localparam int FIFTH_LSB = 16;
	localparam int SIXTH_LSB = 20;
	localparam int SEVENTH_LSB = 24;
	localparam int EIGHTH_LSB = 28;

	localparam logic [STEP_W-1:0] STEP_FIFTH = 3'h4;
	localparam logic [STEP_W-1:0] STEP_SIXTH = 3'h5;
	localparam logic [STEP_W-1:0] STEP_SEVENTH = 3'h6;
	localparam logic [STEP_W-1:0] STEP_EIGHTH = 3'h7;

	typedef logic [FIELD_W-1:0] seq0s_field_t;

endpackage : seq0s_pkg

// [verilog/seq0s_field.sv]
// One two-bit input select field with its own write enable.
`timescale 1ns/1ps
module seq0s_field
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Write side
	input wire logic wr_en,
	input wire logic [seq0s_pkg::FIELD_W-1:0] wr_data,
	// Stored value
	output logic [seq0s_pkg::FIELD_W-1:0] field_value
);

	typedef struct packed
	{
		logic [seq0s_pkg::FIELD_W-1:0] value;
	} seq0s_fstate_t;

	seq0s_fstate_t state_reg;
	seq0s_fstate_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (wr_en)
			state_next.value = wr_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			state_reg <= '{value: seq0s_pkg::FIELD_RESET};
		else
			state_reg <= state_next;
	end

	assign field_value = state_reg.value;

endmodule : seq0s_field

// [verilog/seq0s_step_latch.sv]
// Captures the input selection for a sample step as its conversion starts.
`timescale 1ns/1ps
module seq0s_step_latch
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// All eight fields, field k at bits 2k+1:2k
	input wire logic [seq0s_pkg::NUM_FIELDS*seq0s_pkg::FIELD_W-1:0] fields,
	// Sequencer request
	input wire logic samp_start,
	input wire logic [seq0s_pkg::STEP_W-1:0] samp_step,
	// Converter side
	output logic conv_start,
	output logic [seq0s_pkg::STEP_W-1:0] conv_step,
	output logic [seq0s_pkg::FIELD_W-1:0] conv_input,
	output logic [seq0s_pkg::PIN_COUNT-1:0] ain_enable
);

	typedef struct packed
	{
		logic start;
		logic [seq0s_pkg::STEP_W-1:0] step;
		logic [seq0s_pkg::FIELD_W-1:0] sel;
		logic [seq0s_pkg::PIN_COUNT-1:0] pins;
	} seq0s_lstate_t;

	seq0s_lstate_t state_reg;
	seq0s_lstate_t state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.start = samp_start;
		// Only a new start reloads, so later edits never disturb a sample
		if (samp_start)
		begin
			state_next.step = samp_step;
			state_next.sel = fields[samp_step*seq0s_pkg::FIELD_W +:
				seq0s_pkg::FIELD_W];
			state_next.pins = seq0s_pkg::PIN_COUNT'(1) <<
				fields[samp_step*seq0s_pkg::FIELD_W +:
				seq0s_pkg::FIELD_W];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign conv_start = state_reg.start;
	assign conv_step = state_reg.step;
	assign conv_input = state_reg.sel;
	assign ain_enable = state_reg.pins;

endmodule : seq0s_step_latch

// [verilog/seq0s_input_select.sv]
// Avalon-MM register for sequencer-0 per-sample analog input selection.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module seq0s_input_select
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [seq0s_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [seq0s_pkg::BE_W-1:0] avs_byteenable,
	input wire logic [seq0s_pkg::DATA_W-1:0] avs_writedata,
	output logic [seq0s_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Sequencer request
	input wire logic samp_start,
	input wire logic [seq0s_pkg::STEP_W-1:0] samp_step,
	// Converter side
	output logic conv_start,
	output logic [seq0s_pkg::STEP_W-1:0] conv_step,
	output logic [seq0s_pkg::FIELD_W-1:0] conv_input,
	output logic [seq0s_pkg::PIN_COUNT-1:0] ain_enable
);

	typedef struct packed
	{
		logic ack;
		logic [seq0s_pkg::DATA_W-1:0] rdata;
	} seq0s_bstate_t;

	seq0s_bstate_t state_reg;
	seq0s_bstate_t state_next;

	logic addr_hit;
	logic bus_req;
	logic wr_accept;
	logic rd_accept;
	logic [seq0s_pkg::DATA_W-1:0] sel_word;
	logic [seq0s_pkg::NUM_FIELDS*seq0s_pkg::FIELD_W-1:0] fields;
	logic [seq0s_pkg::FIELD_W-1:0] first_sample_input;
	logic [seq0s_pkg::FIELD_W-1:0] fifth_sample_input;
	logic [seq0s_pkg::FIELD_W-1:0] sixth_sample_input;
	logic [seq0s_pkg::FIELD_W-1:0] seventh_sample_input;
	logic [seq0s_pkg::FIELD_W-1:0] eighth_sample_input;

	assign addr_hit = (avs_address == seq0s_pkg::SEL_REG_OFFSET);
	assign bus_req = avs_read | avs_write;
	// One wait state: the first cycle loads read data, the second completes
	assign avs_waitrequest = bus_req & ~state_reg.ack;
	assign wr_accept = avs_write & state_reg.ack & addr_hit;
	assign rd_accept = avs_read & state_reg.ack;

	always_comb
	begin
		state_next = state_reg;
		state_next.ack = bus_req & ~state_reg.ack;
		if (avs_read & ~state_reg.ack)
		begin
			if (addr_hit)
				state_next.rdata = sel_word;
			else
				state_next.rdata = seq0s_pkg::UNMAPPED_READ;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign avs_readdata = state_reg.rdata;

	// Each field sits four bits apart; reserved pairs are tied low
	genvar k;
	generate
		for (k = 0; k < seq0s_pkg::NUM_FIELDS; k++)
		begin : gen_field
			logic [seq0s_pkg::FIELD_W-1:0] value;
			seq0s_field u_field
			(
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.wr_en(wr_accept & avs_byteenable[k/2]),
				.wr_data(avs_writedata[k*seq0s_pkg::FIELD_STRIDE +:
					seq0s_pkg::FIELD_W]),
				.field_value(value)
			);
			assign sel_word[k*seq0s_pkg::FIELD_STRIDE +:
				seq0s_pkg::FIELD_W] = value;
			assign sel_word[k*seq0s_pkg::FIELD_STRIDE +
				seq0s_pkg::FIELD_W +: seq0s_pkg::FIELD_W] = '0;
			assign fields[k*seq0s_pkg::FIELD_W +:
				seq0s_pkg::FIELD_W] = value;
		end
	endgenerate

	assign first_sample_input = sel_word[seq0s_pkg::FIRST_LSB +:
		seq0s_pkg::FIELD_W];
	assign fifth_sample_input = sel_word[seq0s_pkg::FIFTH_LSB +:
		seq0s_pkg::FIELD_W];
	assign sixth_sample_input = sel_word[seq0s_pkg::SIXTH_LSB +:
		seq0s_pkg::FIELD_W];
	assign seventh_sample_input = sel_word[seq0s_pkg::SEVENTH_LSB +:
		seq0s_pkg::FIELD_W];
	assign eighth_sample_input = sel_word[seq0s_pkg::EIGHTH_LSB +:
		seq0s_pkg::FIELD_W];

	// Step index picks the field; step 7 lands on bits 29:28
	seq0s_step_latch u_latch
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.fields(fields),
		.samp_start(samp_start),
		.samp_step(samp_step),
		.conv_start(conv_start),
		.conv_step(conv_step),
		.conv_input(conv_input),
		.ain_enable(ain_enable)
	);

	sequence s_start_at(logic [seq0s_pkg::STEP_W-1:0] st);
		samp_start && samp_step == st;
	endsequence

	sequence s_full_write;
		wr_accept && avs_byteenable == 4'hf;
	endsequence

	sequence s_read_done;
		rd_accept && addr_hit;
	endsequence

	a_eighth_sample_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(seq0s_pkg::STEP_EIGHTH) |=>
			conv_start && conv_input == $past(eighth_sample_input))
		else $error("eighth sample used wrong field");

	a_seventh_sample_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(seq0s_pkg::STEP_SEVENTH) |=>
			conv_input == $past(seventh_sample_input))
		else $error("seventh sample used wrong field");

	a_sixth_sample_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(seq0s_pkg::STEP_SIXTH) |=>
			conv_input == $past(sixth_sample_input))
		else $error("sixth sample used wrong field");

	a_pin_route_match: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		conv_start |-> ain_enable ==
			(seq0s_pkg::PIN_COUNT'(1) << conv_input) && $onehot(ain_enable))
		else $error("enabled pin differs from selected input");

	a_reserved_reads_zero: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_read_done |-> (avs_readdata & seq0s_pkg::SEL_RSVD_MASK) == '0)
		else $error("reserved bits read as nonzero");

	a_lower_fifth_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(seq0s_pkg::STEP_FIFTH) |=>
			conv_input == $past(fifth_sample_input) && conv_step == 3'h4)
		else $error("fifth sample used wrong field");

	a_lower_first_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(3'h0) |=> conv_input == $past(first_sample_input))
		else $error("first sample used wrong field");

	a_reset_clears_word: assert property (
		@(posedge sys_clk)
		sys_rst |=> sel_word == seq0s_pkg::SEL_REG_RESET)
		else $error("register not zero after reset");

	a_write_then_read: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_full_write |=> sel_word ==
			($past(avs_writedata) & seq0s_pkg::SEL_FIELD_MASK))
		else $error("full write not stored");

	a_wait_one_state: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("slave did not answer after one wait state");

	a_hold_between_starts: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!samp_start |=> $stable(conv_input) && $stable(ain_enable)
			&& !conv_start)
		else $error("selection changed without a new start");

	sequence s_first_cycle;
		bus_req && !state_reg.ack;
	endsequence

	sequence s_top_lane_write;
		wr_accept && avs_byteenable[3];
	endsequence

	sequence s_one_on_eighth;
		s_start_at(seq0s_pkg::STEP_EIGHTH) ##0
			eighth_sample_input == 2'h1;
	endsequence

	a_second_sample_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(3'h1) |=> conv_input == $past(
			sel_word[seq0s_pkg::SECOND_LSB +: seq0s_pkg::FIELD_W]))
		else $error("second sample used wrong field");

	a_third_sample_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(3'h2) |=> conv_input == $past(
			sel_word[seq0s_pkg::THIRD_LSB +: seq0s_pkg::FIELD_W]))
		else $error("third sample used wrong field");

	a_fourth_sample_pick: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_start_at(3'h3) |=> conv_input == $past(
			sel_word[seq0s_pkg::FOURTH_LSB +: seq0s_pkg::FIELD_W]))
		else $error("fourth sample used wrong field");

	a_step_follows_start: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		samp_start |=> conv_start && conv_step == $past(samp_step))
		else $error("converter step differs from requested step");

	a_one_routes_pin_one: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_one_on_eighth |=> conv_input == 2'h1 && ain_enable == 4'h2)
		else $error("input one not routed to pin one");

	a_first_cycle_waits: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_first_cycle |-> avs_waitrequest)
		else $error("first request cycle did not wait");

	a_ack_single_cycle: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		bus_req && !avs_waitrequest |=> avs_waitrequest == bus_req)
		else $error("held request skipped its wait state");

	a_wait_blocks_write: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		avs_write && avs_waitrequest |=> $stable(sel_word))
		else $error("write landed during a wait state");

	a_unmapped_write_ignored: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		avs_write && !addr_hit |=> $stable(sel_word))
		else $error("write to another offset changed the word");

	a_unmapped_read_zero: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		rd_accept && !addr_hit |->
			avs_readdata == seq0s_pkg::UNMAPPED_READ)
		else $error("read of another offset returned data");

	a_read_matches_word: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_read_done |-> avs_readdata == sel_word)
		else $error("read data differs from stored word");

	a_eighth_field_write: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_top_lane_write |=> eighth_sample_input == $past(
			avs_writedata[seq0s_pkg::EIGHTH_LSB +: seq0s_pkg::FIELD_W]))
		else $error("eighth sample field not written");

	a_seventh_field_write: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		s_top_lane_write |=> seventh_sample_input == $past(
			avs_writedata[seq0s_pkg::SEVENTH_LSB +: seq0s_pkg::FIELD_W]))
		else $error("seventh sample field not written");

	a_sixth_field_write: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_accept && avs_byteenable[2] |=> sixth_sample_input == $past(
			avs_writedata[seq0s_pkg::SIXTH_LSB +: seq0s_pkg::FIELD_W]))
		else $error("sixth sample field not written");

	a_masked_lane_keeps: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_accept && !avs_byteenable[3] |=>
			$stable(eighth_sample_input) && $stable(seventh_sample_input))
		else $error("masked byte lane changed its fields");

	a_reset_outputs_zero: assert property (
		@(posedge sys_clk)
		sys_rst |=> !conv_start && conv_input == '0 && ain_enable == '0
			&& avs_readdata == '0)
		else $error("outputs not cleared by reset");

	a_readdata_holds: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");

	a_reserved_never_set: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(sel_word & seq0s_pkg::SEL_RSVD_MASK) == '0)
		else $error("reserved bits hold a one");

endmodule : seq0s_input_select

// [sim/tb_top.sv]
// Self-checking bench for the sequencer-0 input select register.
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic samp_start = 1'b0;
	logic [2:0] samp_step = 3'h0;
	logic conv_start;
	logic [2:0] conv_step;
	logic [1:0] conv_input;
	logic [3:0] ain_enable;
	logic [31:0] rd;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;

	always #25 sys_clk = ~sys_clk;

	seq0s_input_select dut
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.samp_start(samp_start),
		.samp_step(samp_step),
		.conv_start(conv_start),
		.conv_step(conv_step),
		.conv_input(conv_input),
		.ain_enable(ain_enable)
	);

	task automatic results();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// A hung handshake ends the run here instead of spinning forever
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Holds the request until the edge where waitrequest is low
	task automatic bus(input logic is_rd, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n = 0;
		avs_address <= a;
		avs_read <= is_rd;
		avs_write <= ~is_rd;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			n++;
			@(posedge sys_clk);
		end
		check({31'h0, avs_waitrequest}, 32'h0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic samp(input logic [2:0] s, input logic [1:0] pin);
		samp_start <= 1'b1;
		samp_step <= s;
		@(posedge sys_clk);
		samp_start <= 1'b0;
		@(negedge sys_clk);
		check({31'h0, conv_start}, 32'h1);
		check({30'h0, conv_input}, {30'h0, pin});
		check({29'h0, conv_step}, {29'h0, s});
		check({28'h0, ain_enable}, 32'h1 << pin);
		@(posedge sys_clk);
		@(negedge sys_clk);
		check({31'h0, conv_start}, 32'h0);
		@(posedge sys_clk);
	endtask : samp

	task automatic t_reset();
		check({28'h0, ain_enable}, 32'h0);
		bus(1'b1, 8'h40, 32'h0, 4'h0);
		check(rd, 32'h00000000);
	endtask : t_reset

	task automatic t_reserved();
		bus(1'b0, 8'h40, 32'hffffffff, 4'hf);
		bus(1'b1, 8'h40, 32'h0, 4'h0);
		check(rd, 32'h33333333);
	endtask : t_reserved

	task automatic t_lanes();
		logic [31:0] exp;
		exp = 32'h0;
		bus(1'b0, 8'h40, 32'h0, 4'hf);
		for (int b = 0; b < 4; b++)
		begin
			bus(1'b0, 8'h40, 32'hffffffff, 4'h1 << b);
			exp = exp | (32'h33 << (8 * b));
			bus(1'b1, 8'h40, 32'h0, 4'h0);
			check(rd, exp);
		end
	endtask : t_lanes

	// Other offsets must neither answer with data nor disturb the word
	task automatic t_unmapped();
		bus(1'b0, 8'h44, 32'h0, 4'hf);
		bus(1'b1, 8'h44, 32'h0, 4'h0);
		check(rd, 32'h0);
		bus(1'b1, 8'h40, 32'h0, 4'h0);
		check(rd, 32'h33333333);
	endtask : t_unmapped

	task automatic t_steps(input logic [31:0] pat);
		bus(1'b0, 8'h40, pat, 4'hf);
		for (int k = 0; k < 8; k++)
			samp(3'(k), 2'(pat >> (4 * k)));
	endtask : t_steps

	// A rewrite after a start must leave the running sample alone
	task automatic t_midseq();
		bus(1'b0, 8'h40, 32'h10000000, 4'hf);
		samp(3'h7, 2'h1);
		bus(1'b0, 8'h40, 32'h20000000, 4'hf);
		check({30'h0, conv_input}, 32'h1);
		samp(3'h7, 2'h2);
	endtask : t_midseq

	initial
	begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_reserved();
		t_lanes();
		t_unmapped();
		t_steps(32'h32103210);
		t_steps(32'h01230123);
		t_midseq();
		results();
	end
endmodule : tb_top
